// >>> test/ifcfr_frontend.sv
`timescale 1ns/10ps
module ifcfr_frontend (
   input wire logic mclk,
   input wire logic acc_convert,
   input wire logic gyr_convert,
   output logic [15:0] acc_sample,
   output logic [15:0] gyr_sample
);
   // ramps step per conversion, so a dropped sample shows in the fifo
   initial begin
      acc_sample = 16'h0100;
      gyr_sample = 16'h0200;
   end
   always @(posedge mclk) begin
      if (acc_convert) acc_sample <= acc_sample + 16'h0001;
      if (gyr_convert) gyr_sample <= gyr_sample + 16'h0001;
   end
endmodule : ifcfr_frontend

// >>> test/imu_filter_config_and_fifo_rate_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("MISMATCH %s exp %h got %h", n, e, g); \
   end \
end
module imu_filter_config_and_fifo_rate_test;
   import ifcfr_pkg::*;
   logic MCLK = 0, RST_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0;
   logic S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
   logic S_AXI_RVALID, ACC_CONVERT, ACC_ACQUIRE, GYR_CONVERT;
   logic FIFO_FULL, FIFO_WATERMARK, CONFIG_ERROR;
   logic [11:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
   logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, v;
   logic [3:0] S_AXI_WSTRB = 4'hF;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
   logic [15:0] ACC_SAMPLE, GYR_SAMPLE;
   logic [7:0] a, g, d, s;
   int fail_count = 0, samples_checked = 0, seed = 23117, na, ng, nl;
   logic [7:0] ri[6] = '{IDX_ACC_CONF, IDX_GYR_CONF, IDX_DOWNS,
      IDX_FIFO_CFG, IDX_INT_SRC, IDX_ERR};
   logic [7:0] rv[6] = '{ACC_CONF_RST, GYR_CONF_RST, DOWNS_RST, 8'h00,
      8'h00, 8'h00};
   logic [31:0] ct[8] = '{32'h2428_8800, 32'h2D28_8800, 32'h8128_8800,
      32'h8128_0800, 32'h8128_8802, 32'h2825_8800, 32'h283D_8800,
      32'h3828_8800};
   always #2.5 MCLK = ~MCLK;
   ifcfr_top #(.TICK_CYC(8)) u_dut (.MCLK, .RST_N, .S_AXI_AWVALID,
      .S_AXI_AWREADY, .S_AXI_AWADDR, .S_AXI_WVALID, .S_AXI_WREADY,
      .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_BVALID, .S_AXI_BREADY,
      .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR,
      .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP,
      .ACC_SAMPLE, .GYR_SAMPLE, .ACC_CONVERT, .ACC_ACQUIRE, .GYR_CONVERT,
      .FIFO_FULL, .FIFO_WATERMARK, .CONFIG_ERROR);
   ifcfr_frontend u_fe (.mclk(MCLK), .acc_convert(ACC_CONVERT),
      .gyr_convert(GYR_CONVERT), .acc_sample(ACC_SAMPLE),
      .gyr_sample(GYR_SAMPLE));
   task automatic wrap_up;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [7:0] i, input logic [31:0] x);
      int n;
      n = 0;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_AWADDR <= {2'b00, i, 2'b00};
      S_AXI_WDATA <= x;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         n++;
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1 && n < 99);
      if (n >= 99) fail_count++;
      if (n >= 99) wrap_up();
      r = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
      @(posedge MCLK);
   endtask : wr
   task automatic rd(input logic [7:0] i);
      int n;
      n = 0;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_ARADDR <= {2'b00, i, 2'b00};
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         n++;
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1 && n < 99);
      if (n >= 99) fail_count++;
      if (n >= 99) wrap_up();
      v = S_AXI_RDATA;
      r = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
      @(posedge MCLK);
   endtask : rd
   function automatic logic [3:0] exp_err();
      if (a[7] && (s[1:0] != 2'b00 || !d[7])) return 4'h3;
      if (a[3:0] < (a[7] ? 1 : 5) || a[3:0] > 12) return 4'h1;
      if (g[3:0] < 6 || g[3:0] > 13) return 4'h2;
      if (!a[7] && a[6:4] > 2) return 4'h4;
      if (g[6:4] > 2) return 4'h5;
      return 4'h0;
   endfunction : exp_err
   task automatic cfg;
      wr(IDX_ACC_CONF, {24'h0, a});
      wr(IDX_GYR_CONF, {24'h0, g});
      wr(IDX_DOWNS, {24'h0, d});
      wr(IDX_INT_SRC, {24'h0, s});
      rd(IDX_ERR);
      `CHK("err", {27'h0, exp_err(), 1'b0}, v)
      `CHK("flag", exp_err() != 4'h0, CONFIG_ERROR)
   endtask : cfg
   initial begin
      repeat (20) @(posedge MCLK);
      RST_N <= 1'b1;
      @(posedge MCLK);
      foreach (ri[k]) begin
         rd(ri[k]);
         `CHK("reset", {24'h0, rv[k]}, v)
      end
      wr(IDX_ERR, 32'h1E);
      `CHK("ro_resp", RESP_OKAY, r)
      rd(IDX_ERR);
      `CHK("ro", 32'h0, v)
      wr(8'h10, 32'h1);
      `CHK("wdec", RESP_DECERR, r)
      rd(8'h10);
      `CHK("rdec", {RESP_DECERR, 32'h0}, {r, v})
      $display("bus test done");
      foreach (ct[k]) begin
         {a, g, d, s} = ct[k];
         cfg();
      end
      repeat (30) begin
         {a, g, d, s} = $random(seed);
         g[7] = 1'b0;
         s[7:2] = 6'h00;
         cfg();
      end
      $display("error test done");
      {d, s} = 16'h8800;
      for (int k = 0; k < 4; k++) begin
         g = 8'h0A | 8'(k % 3 << 4);
         a = (k < 3) ? g : 8'h9A;
         cfg();
         repeat (256) @(posedge MCLK);
         {na, ng, nl} = 0;
         repeat (1024) begin
            @(negedge MCLK);
            na += (ACC_CONVERT === 1'b1);
            ng += (GYR_CONVERT === 1'b1);
            nl += (ACC_ACQUIRE === 1'b0);
         end
         `CHK("acc_cnv", k < 3 ? 8 << (2 - k) : 16, na)
         `CHK("gyr_cnv", 8 << (2 - k % 3), ng)
         `CHK("acq_low", k == 3, nl > 0)
      end
      $display("rate test done");
      {a, g, d, s} = 32'h2C28_8800;
      cfg();
      rd(IDX_FIFO_DATA);
      `CHK("empty", 32'h80, v)
      wr(IDX_FIFO_CFG, 32'h0101);
      repeat (200) @(posedge MCLK);
      `CHK("wmark", 1'b1, FIFO_WATERMARK)
      repeat (17000) @(posedge MCLK);
      `CHK("full", 1'b1, FIFO_FULL)
      wr(IDX_FIFO_CFG, 32'h0);
      rd(IDX_FIFO_LEN);
      `CHK("len", 32'h400, v)
      // two oldest frames must be neighbouring ramp samples
      for (int k = 0; k < 4; k++) begin
         rd(IDX_FIFO_DATA);
         {a, g, d, s} = {g, d, s, v[7:0]};
      end
      `CHK("next", {g, a} + 16'h0001, {s, d})
      rd(IDX_FIFO_LEN);
      `CHK("pop", 32'h3FC, v)
      $display("fifo test done");
      wrap_up();
   end
endmodule : imu_filter_config_and_fifo_rate_test

// >>> verilog/ifcfr_pkg.sv
// Behaviour
// - illegal configuration sets an error code; fifo then stores nothing
// - normal accel samples equidistantly at its rate, 12.5 Hz to 1600 Hz
// - accel rate below 12.5 Hz without undersampling is an error
// - accel filter 001 runs two-times oversampling
// - accel filter 000 runs four-times oversampling
// - undersampling alternates suspend and acquisition phases, period from rate
// - undersampling accepts twelve rates from 0.78 Hz to 1600 Hz
// - undersampling averages two-to-filter samples per period, skips the rest
// - undersampling with pre-filtered data selected is an error
// - pre-filtered means motion or tap source set, or accel fifo unfiltered
// - gyro has no undersampling or low power path
// - gyro normal filter samples equidistantly, 25 Hz to 3200 Hz
// - gyro rate below 25 Hz is an error
// - gyro filter 001 runs two-times oversampling
// - gyro filter 000 runs four-times oversampling up to 1600 Hz, two-times at 3200 Hz
// - fifo holds 1024 bytes shared between sensors
// - fifo raises full and watermark indications
// - reads of the fifo data register return successive stored bytes
// - frame rate equals highest rate of sensors enabled for fifo
// - pre-filtered fifo data runs at 6400 Hz gyro, 1600 Hz accel
// - per-sensor fifo downsampling only drops samples
package ifcfr_pkg;
   // ***********************************************************
   // register indices, byte address is four times the index
   // ***********************************************************
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_ERR = 8'h02;
   localparam logic [7:0] IDX_ACC_OUT = 8'h04;
   localparam logic [7:0] IDX_GYR_OUT = 8'h06;
   localparam logic [7:0] IDX_FIFO_LEN = 8'h22;
   localparam logic [7:0] IDX_FIFO_DATA = 8'h24;
   localparam logic [7:0] IDX_ACC_CONF = 8'h40;
   localparam logic [7:0] IDX_GYR_CONF = 8'h42;
   localparam logic [7:0] IDX_DOWNS = 8'h45;
   localparam logic [7:0] IDX_FIFO_CFG = 8'h46;
   localparam logic [7:0] IDX_INT_SRC = 8'h58;
   // ***********************************************************
   // field positions and reset values
   // ***********************************************************
   localparam int RATE_LSB = 0;
   localparam int FILT_LSB = 4;
   localparam int ACCEL_UNDERSAMPLE_EN_BIT = 7;
   localparam int GYR_DS_LSB = 0;
   localparam int GYR_FILT_DATA_BIT = 3;
   localparam int ACC_DS_LSB = 4;
   localparam int ACC_FILT_DATA_BIT = 7;
   localparam int ACC_EN_BIT = 0;
   localparam int GYR_EN_BIT = 1;
   localparam int WM_LSB = 8;
   localparam int MOTION_SRC_BIT = 0;
   localparam int TAP_SRC_BIT = 1;
   localparam int ERR_CODE_LSB = 1;
   localparam logic [7:0] ACC_CONF_RST = 8'h28;
   localparam logic [7:0] GYR_CONF_RST = 8'h28;
   localparam logic [7:0] DOWNS_RST = 8'h88;
   localparam logic [15:0] FIFO_CFG_RST = 16'h0000;
   localparam logic [15:0] INT_SRC_RST = 16'h0000;
   // ***********************************************************
   // rate codes: rate = 3200 Hz / 2^(13 - code)
   // ***********************************************************
   localparam logic [3:0] RATE_ACC_LP_MIN = 4'h1;
   localparam logic [3:0] RATE_ACC_MIN = 4'h5;
   localparam logic [3:0] RATE_ACC_MAX = 4'hC;
   localparam logic [3:0] RATE_GYR_MIN = 4'h6;
   localparam logic [3:0] RATE_GYR_MAX = 4'hD;
   localparam logic [3:0] RATE_1600 = 4'hC;
   localparam logic [3:0] RATE_6400 = 4'hE;
   localparam logic [2:0] FILT_NORMAL = 3'h2;
   localparam logic [2:0] FILT_DOUBLE = 3'h1;
   localparam logic [2:0] FILT_QUAD = 3'h0;
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_ACC_RATE = 4'h1;
   localparam logic [3:0] ERR_GYR_RATE = 4'h2;
   localparam logic [3:0] ERR_US_PREFILT = 4'h3;
   localparam logic [3:0] ERR_ACC_FILT = 4'h4;
   localparam logic [3:0] ERR_GYR_FILT = 4'h5;
   // ***********************************************************
   // fifo, bus answers and timing
   // ***********************************************************
   localparam int FIFO_BYTES = 1024;
   localparam logic [10:0] FIFO_FULL_CNT = 11'h400;
   localparam logic [7:0] EMPTY_BYTE = 8'h80;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam int CLK_PERIOD_NS = 5;
   localparam int MCLK_HZ = 1000000000 / CLK_PERIOD_NS;
   localparam int BASE_RATE_HZ = 6400;
   localparam int TICK_CYCLES = MCLK_HZ / BASE_RATE_HZ;
endpackage : ifcfr_pkg

// >>> verilog/ifcfr_top.sv
`timescale 1ns/10ps
module ifcfr_top #(
   parameter int unsigned TICK_CYC = ifcfr_pkg::TICK_CYCLES
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [ifcfr_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [ifcfr_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   input wire logic [15:0] ACC_SAMPLE,
   input wire logic [15:0] GYR_SAMPLE,
   output logic ACC_CONVERT,
   output logic ACC_ACQUIRE,
   output logic GYR_CONVERT,
   output logic FIFO_FULL,
   output logic FIFO_WATERMARK,
   output logic CONFIG_ERROR
);
   import ifcfr_pkg::*;
   localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);
   // ***********************************************************
   // register bus
   // ***********************************************************
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [7:0] acc_conf_q, gyr_conf_q, downs_q;
   logic [15:0] fcfg_q, int_q;
   logic [3:0] err_q;
   logic cfg_err_q;
   wire aw_take = S_AXI_AWVALID && awready_q;
   wire w_take = S_AXI_WVALID && wready_q;
   wire wr_go = !awready_q && !wready_q && !bvalid_q;
   wire rd_take = S_AXI_ARVALID && arready_q;
   wire [7:0] wr_idx = awaddr_q[9:2];
   wire [7:0] rd_idx = S_AXI_ARADDR[9:2];
   wire wr_top0 = (awaddr_q[11:10] == 2'h0);
   wire rd_top0 = (S_AXI_ARADDR[11:10] == 2'h0);
   wire wr_acc = wr_top0 && wr_idx == IDX_ACC_CONF;
   wire wr_gyr = wr_top0 && wr_idx == IDX_GYR_CONF;
   wire wr_downs = wr_top0 && wr_idx == IDX_DOWNS;
   wire wr_fcfg = wr_top0 && wr_idx == IDX_FIFO_CFG;
   wire wr_int = wr_top0 && wr_idx == IDX_INT_SRC;
   // read-only registers accept writes silently so software sees OKAY
   wire wr_ro = wr_top0 && (wr_idx == IDX_ERR || wr_idx == IDX_ACC_OUT
      || wr_idx == IDX_GYR_OUT || wr_idx == IDX_FIFO_LEN
      || wr_idx == IDX_FIFO_DATA);
   wire wr_map = wr_acc || wr_gyr || wr_downs || wr_fcfg || wr_int || wr_ro;
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (aw_take) begin
            awready_q <= 1'b0;
            awaddr_q <= S_AXI_AWADDR;
         end
         if (w_take) begin
            wready_q <= 1'b0;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_map ? RESP_OKAY : RESP_DECERR;
         end else if (bvalid_q && S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         acc_conf_q <= ACC_CONF_RST;
         gyr_conf_q <= GYR_CONF_RST;
         downs_q <= DOWNS_RST;
         fcfg_q <= FIFO_CFG_RST;
         int_q <= INT_SRC_RST;
      end else begin
         if (wr_go && wr_acc && wstrb_q[0]) acc_conf_q <= wdata_q[7:0];
         if (wr_go && wr_gyr && wstrb_q[0]) gyr_conf_q <= wdata_q[7:0];
         if (wr_go && wr_downs && wstrb_q[0]) downs_q <= wdata_q[7:0];
         if (wr_go && wr_fcfg && wstrb_q[0]) fcfg_q[7:0] <= wdata_q[7:0];
         if (wr_go && wr_fcfg && wstrb_q[1]) fcfg_q[15:8] <= wdata_q[15:8];
         if (wr_go && wr_int && wstrb_q[0]) int_q[7:0] <= wdata_q[7:0];
         if (wr_go && wr_int && wstrb_q[1]) int_q[15:8] <= wdata_q[15:8];
      end
   end
   // ***********************************************************
   // configuration checking
   // ***********************************************************
   wire [3:0] acc_rate = acc_conf_q[RATE_LSB +: 4];
   wire [2:0] acc_filt = acc_conf_q[FILT_LSB +: 3];
   wire accel_undersample_en = acc_conf_q[ACCEL_UNDERSAMPLE_EN_BIT];
   wire [3:0] gyr_rate = gyr_conf_q[RATE_LSB +: 4];
   wire [2:0] gyr_filt = gyr_conf_q[FILT_LSB +: 3];
   wire acc_ff = downs_q[ACC_FILT_DATA_BIT];
   wire gyr_ff = downs_q[GYR_FILT_DATA_BIT];
   wire [2:0] acc_ds = downs_q[ACC_DS_LSB +: 3];
   wire [2:0] gyr_ds = downs_q[GYR_DS_LSB +: 3];
   wire acc_lo_bad = accel_undersample_en ? (acc_rate < RATE_ACC_LP_MIN)
                            : (acc_rate < RATE_ACC_MIN);
   wire acc_rate_bad = acc_lo_bad || acc_rate > RATE_ACC_MAX;
   wire prefilt_sel = int_q[MOTION_SRC_BIT] || int_q[TAP_SRC_BIT]
      || !acc_ff;
   wire us_conflict = accel_undersample_en && prefilt_sel;
   // host may pick normal or oversampling filters; codes above normal are caught unless undersampling
   wire acc_filt_bad = !accel_undersample_en && acc_filt > FILT_NORMAL;
   wire gyr_rate_bad = gyr_rate < RATE_GYR_MIN
      || gyr_rate > RATE_GYR_MAX;
   wire gyr_filt_bad = gyr_filt > FILT_NORMAL;
   wire [3:0] err_d = us_conflict ? ERR_US_PREFILT
      : acc_rate_bad ? ERR_ACC_RATE
      : gyr_rate_bad ? ERR_GYR_RATE
      : acc_filt_bad ? ERR_ACC_FILT
      : gyr_filt_bad ? ERR_GYR_FILT : ERR_NONE;
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         err_q <= ERR_NONE;
         cfg_err_q <= 1'b0;
      end else begin
         err_q <= err_d;
         cfg_err_q <= (err_d != ERR_NONE);
      end
   end
   // ***********************************************************
   // 6400 Hz timebase
   // ***********************************************************
   logic [15:0] tick_cnt_q, ts_q;
   wire tick = (tick_cnt_q == TICK_LAST);
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         tick_cnt_q <= 16'h0000;
         ts_q <= 16'h0000;
      end else begin
         tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
         if (tick) ts_q <= ts_q + 16'h0001;
      end
   end
   // true on ticks that belong to the given rate code
   function automatic logic rate_hit(input logic [15:0] ts,
                                     input logic [3:0] code);
      logic [15:0] m;
      m = (16'h0001 << (4'hE - code)) - 16'h0001;
      rate_hit = ((ts & m) == 16'h0000);
   endfunction : rate_hit
   function automatic logic [3:0] os_code(input logic [3:0] rate,
                                          input logic [2:0] filt);
      logic [3:0] c;
      c = (filt == FILT_QUAD) ? rate + 4'h2
        : (filt == FILT_DOUBLE) ? rate + 4'h1 : rate;
      // conversions never run above the 6400 Hz base rate
      os_code = (c > RATE_6400) ? RATE_6400 : c;
   endfunction : os_code
   // ***********************************************************
   // accelerometer path
   // ***********************************************************
   logic [15:0] acc_out_q, gyr_out_q;
   logic acq_q, acc_conv_q, acc_acq_q, gyr_conv_q;
   logic [7:0] acq_left_q;
   logic signed [22:0] acc_sum_q;
   wire acc_hit = tick && rate_hit(ts_q, acc_rate);
   wire acc_os_hit = tick
      && rate_hit(ts_q, os_code(acc_rate, acc_filt));
   wire lp_samp = tick && acq_q && rate_hit(ts_q, RATE_1600);
   wire [7:0] avg_n = 8'h01 << acc_filt;
   wire us_take = accel_undersample_en && (acc_hit || lp_samp);
   wire [7:0] left_in = acc_hit ? avg_n : acq_left_q;
   wire signed [22:0] sum_base = acc_hit ? 23'sh00_0000 : acc_sum_q;
   wire signed [22:0] sum_in = sum_base + 23'(signed'(ACC_SAMPLE));
   wire signed [22:0] avg_val = sum_in >>> acc_filt;
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         acq_q <= 1'b0;
         acq_left_q <= 8'h00;
         acc_sum_q <= 23'sh00_0000;
         acc_out_q <= 16'h0000;
      end else if (accel_undersample_en) begin
         // suspend between bursts; a new period restarts the burst
         if (us_take && left_in == 8'h01) begin
            acq_q <= 1'b0;
            acc_out_q <= avg_val[15:0];
         end else if (us_take) begin
            acq_q <= 1'b1;
            acq_left_q <= left_in - 8'h01;
            acc_sum_q <= sum_in;
         end
      end else begin
         acq_q <= 1'b0;
         if (acc_hit) acc_out_q <= ACC_SAMPLE;
      end
   end
   // ***********************************************************
   // gyroscope path, normal power only, plus accel and gyro convert and accel acquire outputs
   // ***********************************************************
   wire gyr_hit = tick && rate_hit(ts_q, gyr_rate);
   wire gyr_os_hit = tick
      && rate_hit(ts_q, os_code(gyr_rate, gyr_filt));
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         gyr_out_q <= 16'h0000;
         acc_conv_q <= 1'b0;
         acc_acq_q <= 1'b0;
         gyr_conv_q <= 1'b0;
      end else begin
         if (gyr_hit) gyr_out_q <= GYR_SAMPLE;
         acc_conv_q <= accel_undersample_en ? us_take : acc_os_hit;
         acc_acq_q <= !accel_undersample_en || acq_q || us_take;
         gyr_conv_q <= gyr_os_hit;
      end
   end
   // ***********************************************************
   // fifo input selection and downsampling
   // ***********************************************************
   wire [3:0] acc_eff = acc_ff ? acc_rate : RATE_1600;
   wire [3:0] gyr_eff = gyr_ff ? gyr_rate : RATE_6400;
   wire [3:0] acc_dec = ({1'b0, acc_ds} > acc_eff) ? 4'h0
      : acc_eff - {1'b0, acc_ds};
   wire [3:0] gyr_dec = ({1'b0, gyr_ds} > gyr_eff) ? 4'h0
      : gyr_eff - {1'b0, gyr_ds};
   wire acc_in = fcfg_q[ACC_EN_BIT] && tick && rate_hit(ts_q, acc_dec);
   wire gyr_in = fcfg_q[GYR_EN_BIT] && tick && rate_hit(ts_q, gyr_dec);
   logic acc_in_q, gyr_in_q;
   logic [31:0] wr_buf_q;
   logic [2:0] wr_left_q;
   logic [9:0] wr_ptr_q, rd_ptr_q;
   logic [10:0] fifo_cnt_q;
   logic full_q, wm_q;
   logic [7:0] fifo_mem [0:FIFO_BYTES-1];
   wire [15:0] acc_fdata = acc_ff ? acc_out_q : ACC_SAMPLE;
   wire [15:0] gyr_fdata = gyr_ff ? gyr_out_q : GYR_SAMPLE;
   // a frame waits one cycle so the data registers hold this tick's sample
   wire frame_go = (acc_in_q || gyr_in_q) && err_q == ERR_NONE
      && wr_left_q == 3'h0;
   wire fifo_full = (fifo_cnt_q == FIFO_FULL_CNT);
   wire mem_we = (wr_left_q != 3'h0) && !fifo_full;
   wire rd_fifo = rd_take && rd_top0 && rd_idx == IDX_FIFO_DATA;
   wire pop = rd_fifo && fifo_cnt_q != 11'h000;
   wire [10:0] cnt_d = fifo_cnt_q + {10'h000, mem_we} - {10'h000, pop};
   wire [7:0] wm = fcfg_q[WM_LSB +: 8];
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         acc_in_q <= 1'b0;
         gyr_in_q <= 1'b0;
         wr_buf_q <= 32'h0000_0000;
         wr_left_q <= 3'h0;
      end else begin
         acc_in_q <= acc_in;
         gyr_in_q <= gyr_in;
         if (frame_go && acc_in_q && gyr_in_q) begin
            wr_buf_q <= {gyr_fdata, acc_fdata};
            wr_left_q <= 3'h4;
         end else if (frame_go) begin
            wr_buf_q <= {16'h0000, acc_in_q ? acc_fdata : gyr_fdata};
            wr_left_q <= 3'h2;
         end else if (wr_left_q != 3'h0) begin
            // bytes arriving while full are lost, newest data is dropped
            wr_buf_q <= {8'h00, wr_buf_q[31:8]};
            wr_left_q <= wr_left_q - 3'h1;
         end
      end
   end
   always_ff @(posedge MCLK) begin
      if (mem_we) fifo_mem[wr_ptr_q] <= wr_buf_q[7:0];
   end
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         wr_ptr_q <= 10'h000;
         rd_ptr_q <= 10'h000;
         fifo_cnt_q <= 11'h000;
         full_q <= 1'b0;
         wm_q <= 1'b0;
      end else begin
         if (mem_we) wr_ptr_q <= wr_ptr_q + 10'h001;
         if (pop) rd_ptr_q <= rd_ptr_q + 10'h001;
         fifo_cnt_q <= cnt_d;
         full_q <= (cnt_d == FIFO_FULL_CNT);
         wm_q <= (wm != 8'h00)
            && (cnt_d >= {1'b0, wm, 2'b00});
      end
   end
   // ***********************************************************
   // read side of the bus
   // ***********************************************************
   wire [7:0] fifo_byte = (fifo_cnt_q != 11'h000) ? fifo_mem[rd_ptr_q]
      : EMPTY_BYTE;
   wire [31:0] rd_data =
        (rd_idx == IDX_ERR) ? 32'({err_q, 1'b0})
      : (rd_idx == IDX_ACC_OUT) ? 32'(acc_out_q)
      : (rd_idx == IDX_GYR_OUT) ? 32'(gyr_out_q)
      : (rd_idx == IDX_FIFO_LEN) ? 32'(fifo_cnt_q)
      : (rd_idx == IDX_FIFO_DATA) ? 32'(fifo_byte)
      : (rd_idx == IDX_ACC_CONF) ? 32'(acc_conf_q)
      : (rd_idx == IDX_GYR_CONF) ? 32'(gyr_conf_q)
      : (rd_idx == IDX_DOWNS) ? 32'(downs_q)
      : (rd_idx == IDX_FIFO_CFG) ? 32'(fcfg_q)
      : (rd_idx == IDX_INT_SRC) ? 32'(int_q) : 32'h0000_0000;
   wire rd_map = rd_top0 && (rd_idx == IDX_ERR || rd_idx == IDX_ACC_OUT
      || rd_idx == IDX_GYR_OUT || rd_idx == IDX_FIFO_LEN
      || rd_idx == IDX_FIFO_DATA || rd_idx == IDX_ACC_CONF
      || rd_idx == IDX_GYR_CONF || rd_idx == IDX_DOWNS
      || rd_idx == IDX_FIFO_CFG || rd_idx == IDX_INT_SRC);
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (rd_take) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_map ? rd_data : 32'h0000_0000;
         rresp_q <= rd_map ? RESP_OKAY : RESP_DECERR;
      end else if (rvalid_q && S_AXI_RREADY) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
      end
   end
   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
   assign ACC_CONVERT = acc_conv_q;
   assign ACC_ACQUIRE = acc_acq_q;
   assign GYR_CONVERT = gyr_conv_q;
   assign FIFO_FULL = full_q;
   assign FIFO_WATERMARK = wm_q;
   assign CONFIG_ERROR = cfg_err_q;
   // ***********************************************************
   // checks
   // ***********************************************************
   a_err_acc_rate: assert property (
      !accel_undersample_en && acc_rate < RATE_ACC_MIN |=> err_q != ERR_NONE)
      else $error("low accel rate not flagged");
   a_err_us_prefilt: assert property (
      accel_undersample_en && !acc_ff |=> err_q == ERR_US_PREFILT && CONFIG_ERROR)
      else $error("undersampling with unfiltered fifo not flagged");
   a_err_gyr_rate: assert property (
      gyr_rate < RATE_GYR_MIN |=> err_q == ERR_GYR_RATE
      || err_q == ERR_US_PREFILT || err_q == ERR_ACC_RATE)
      else $error("low gyro rate not flagged");
   a_err_blocks_fifo: assert property (
      err_q != ERR_NONE && wr_left_q == 3'h0 |=> wr_left_q == 3'h0)
      else $error("fifo written under illegal setting");
   a_normal_sample: assert property (
      acc_hit && !accel_undersample_en |=> acc_out_q == $past(ACC_SAMPLE))
      else $error("accel sample not taken at rate point");
   a_us_burst_len: assert property (
      accel_undersample_en && acc_hit && avg_n > 8'h01 |=> acq_q
      && acq_left_q == $past(avg_n) - 8'h01)
      else $error("averaging burst length wrong");
   a_fifo_full_flag: assert property (
      cnt_d == FIFO_FULL_CNT |=> FIFO_FULL && !mem_we)
      else $error("full flag missing or write while full");
   a_fifo_pop_order: assert property (
      pop && !mem_we |=> fifo_cnt_q == $past(fifo_cnt_q) - 11'h001
      && rd_ptr_q == $past(rd_ptr_q) + 10'h001)
      else $error("fifo read did not advance");
   a_frame_bytes: assert property (
      frame_go && acc_in_q && gyr_in_q |=> wr_left_q == 3'h4 ##1
      wr_left_q == 3'h3 ##1 wr_left_q == 3'h2)
      else $error("frame byte sequence wrong");
   a_bresp_hold: assert property (
      bvalid_q && !S_AXI_BREADY |=> bvalid_q && $stable(bresp_q))
      else $error("write response dropped");
   c_us_average: cover property (accel_undersample_en && us_take && left_in == 8'h01);
   c_fifo_full: cover property ($rose(full_q));
   c_fifo_readback: cover property (pop ##[1:4] rvalid_q);
   c_cfg_error: cover property ($rose(cfg_err_q));
endmodule : ifcfr_top
